// ==== dlt_defs.svh ====
// Register indexes, field positions, reset values and line codes of the datalink 3 transmitter
`ifndef DLT_DEFS_SVH
`define DLT_DEFS_SVH
`define DLT_IDX_CTRL     10'h153
`define DLT_IDX_COUNT    10'h154
`define DLT_IDX_DATA     10'h156
`define DLT_IDX_STATUS   10'h157
`define DLT_IDX_BOSCODE  10'h158
`define DLT_CTRL_TYPE    0
`define DLT_CTRL_FCS     1
`define DLT_CTRL_IDLE    2
`define DLT_CTRL_RST     3'h0
`define DLT_COUNT_RST    7'h00
`define DLT_BOSCODE_RST  8'h00
`define DLT_DATA_LAST    8
`define DLT_STAT_EOT     0
`define DLT_FLAG         8'h7E
`define DLT_BOS_LEAD     8'hFF
`define DLT_CRC_INIT     16'hFFFF
`define DLT_CRC_POLY     16'h8408
`define DLT_STUFF_RUN    3'h5
`define DLT_OCTET_BITS   5'h08
`define DLT_WORD_BITS    5'h10
`define DLT_RESP_OKAY    2'h0
`define DLT_RESP_SLVERR  2'h2
`endif

// ==== dlt_pkg.sv ====
// Types shared by the datalink 3 transmit control block
package dlt_pkg;
   typedef enum logic [1:0] {ST_FLAG, ST_DATA, ST_FCS, ST_BOS} dlt_tx_e;
   typedef struct packed {
      logic idle;
      logic fcs;
      logic message_oriented_signaling;
   } dlt_ctrl_s;
   typedef struct packed {
      logic       last;
      logic [7:0] octet;
   } dlt_item_s;
   typedef struct packed {
      logic            aw_rdy;
      logic            w_rdy;
      logic [9:0]      waddr;
      logic [8:0]      wdata;
      logic            wstrb;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            push;
      dlt_item_s       push_item;
      logic            ar_rdy;
      logic            rvalid;
      logic [1:0]      rresp;
      logic [7:0]      rdata;
      dlt_ctrl_s       ctrl;
      logic [6:0]      count;
      logic [7:0]      boscode;
      logic            eot;
      logic            bos_pend;
      dlt_tx_e         txs;
      logic [15:0]     sh;
      logic [4:0]      left;
      logic [2:0]      ones;
      logic [15:0]     crc;
      logic            last;
      logic [6:0]      reps;
      logic            dl_bit;
   } dlt_state_s;
endpackage

// ==== dlt_fifo.sv ====
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module dlt_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input  wire logic             clock,      // System clock
   input  wire logic             rst_n,      // Synchronous reset, active low
   input  wire logic             in_valid,   // Producer offers a word
   output wire logic             in_ready,   // Room for a word
   input  wire logic [WIDTH-1:0] in_data,    // Word in
   output wire logic             out_valid,  // Word available
   input  wire logic             out_ready,  // Consumer takes the word
   output wire logic [WIDTH-1:0] out_data    // Head word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [CW-1:0]               cnt;
   } dlt_fifo_s;

   dlt_fifo_s st;
   dlt_fifo_s next_st;
   logic      do_wr;
   logic      do_rd;

   // Full and empty straight from the occupancy count
   assign in_ready  = (st.cnt != CW'(DEPTH));
   assign out_valid = (st.cnt != '0);
   assign out_data  = st.mem[st.rd];

   // Pointer and count update
   always_comb begin
      next_st = st;
      do_wr   = in_valid & in_ready;
      do_rd   = out_valid & out_ready;
      if (do_wr) begin
         next_st.mem[st.wr] = in_data;
         next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
      end
      if (do_rd) begin
         next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
      end
      next_st.cnt = st.cnt + CW'(do_wr) - CW'(do_rd);
   end

   // State register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   chk_fifo_count_up: assert property (@(posedge clock) disable iff (!rst_n)
      do_wr && !do_rd |=> st.cnt == $past(st.cnt) + 1'b1)
      else $error("fifo count did not rise on write");
   chk_fifo_full_hold: assert property (@(posedge clock) disable iff (!rst_n)
      !in_ready && !out_ready |=> !in_ready)
      else $error("fifo lost a word while full");
endmodule

// ==== dlt_tx_ctrl.sv ====
// Datalink 3 transmit control: AXI4-Lite registers, flag/frame/BIT_ORIENTED_SIGNALING serializer with FCS
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "dlt_defs.svh"
module dlt_tx_ctrl #(
   parameter int ADDR_W     = 12,
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic              CLOCK,    // System clock, 250 MHz
   input  wire logic              RST_N,    // Synchronous reset, active low
   input  wire logic [ADDR_W-1:0] AWADDR,   // Write address
   input  wire logic              AWVALID,  // Write address valid
   output wire logic              AWREADY,  // Write address ready
   input  wire logic [31:0]       WDATA,    // Write data
   input  wire logic [3:0]        WSTRB,    // Write byte strobes
   input  wire logic              WVALID,   // Write data valid
   output wire logic              WREADY,   // Write data ready
   output wire logic [1:0]        BRESP,    // Write response
   output wire logic              BVALID,   // Write response valid
   input  wire logic              BREADY,   // Write response ready
   input  wire logic [ADDR_W-1:0] ARADDR,   // Read address
   input  wire logic              ARVALID,  // Read address valid
   output wire logic              ARREADY,  // Read address ready
   output wire logic [31:0]       RDATA,    // Read data
   output wire logic [1:0]        RRESP,    // Read response
   output wire logic              RVALID,   // Read data valid
   input  wire logic              RREADY,   // Read data ready
   input  wire logic              DL_SLOT,  // Datalink bit slot strobe from framer
   output wire logic              DL_BIT,   // Datalink bit for the slot
   output wire logic              TX_EOT    // Sticky end of transfer
);
   dlt_pkg::dlt_state_s st;
   dlt_pkg::dlt_state_s next_st;
   dlt_pkg::dlt_item_s  fifo_head;
   logic                fifo_in_ready;
   logic                fifo_valid;
   logic                pop;
   logic                done;
   logic                idle_on;
   logic                fcs_on;
   logic                ctrl_wr;
   logic                want_octet;
   logic                want_flag;
   logic                b;
   logic [9:0]          ridx;

   // Outbound octet queue between the register bus and the serializer
   dlt_fifo #(
      .WIDTH ($bits(dlt_pkg::dlt_item_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (CLOCK),
      .rst_n     (RST_N),
      .in_valid  (st.push),
      .in_ready  (fifo_in_ready),
      .in_data   (st.push_item),
      .out_valid (fifo_valid),
      .out_ready (pop),
      .out_data  (fifo_head)
   );

   // Mode qualifiers: idle and FCS only count in message mode
   assign idle_on = st.ctrl.idle & st.ctrl.message_oriented_signaling;
   assign fcs_on  = st.ctrl.fcs & st.ctrl.message_oriented_signaling;
   assign ridx    = ARADDR[ADDR_W-1:2];

   // Outputs from the state register
   assign AWREADY = st.aw_rdy;
   assign WREADY  = st.w_rdy;
   assign BVALID  = st.bvalid;
   assign BRESP   = st.bresp;
   assign ARREADY = st.ar_rdy;
   assign RVALID  = st.rvalid;
   assign RRESP   = st.rresp;
   assign RDATA   = {24'h000000, st.rdata};
   assign DL_BIT  = st.dl_bit;
   assign TX_EOT  = st.eot;

   // Next state: bus slave first, then serializer, so an end-of-transfer set beats a status-write clear
   always_comb begin
      next_st    = st;
      pop        = 1'b0;
      done       = 1'b0;
      ctrl_wr    = 1'b0;
      want_octet = 1'b0;
      want_flag  = 1'b0;
      b          = 1'b0;
      // Write address and data, taken in either order
      if (AWVALID && st.aw_rdy) begin
         next_st.aw_rdy = 1'b0;
         next_st.waddr  = AWADDR[ADDR_W-1:2];
      end
      if (WVALID && st.w_rdy) begin
         next_st.w_rdy = 1'b0;
         next_st.wdata = WDATA[8:0];
         next_st.wstrb = WSTRB[0];
      end
      // Execute a write once both halves are held
      if (!st.aw_rdy && !st.w_rdy && !st.bvalid && !st.push) begin
         next_st.bvalid = 1'b1;
         next_st.bresp  = `DLT_RESP_OKAY;
         case (st.waddr)
            `DLT_IDX_CTRL: begin
               if (st.wstrb) begin
                  ctrl_wr      = 1'b1;
                  next_st.ctrl = st.wdata[2:0];
                  if (!st.wdata[`DLT_CTRL_TYPE]) begin
                     next_st.bos_pend = 1'b1;
                  end
               end
            end
            `DLT_IDX_COUNT: begin
               if (st.wstrb) begin
                  next_st.count = st.wdata[6:0];
               end
            end
            `DLT_IDX_BOSCODE: begin
               if (st.wstrb) begin
                  next_st.boscode = st.wdata[7:0];
               end
            end
            `DLT_IDX_DATA: begin
               if (st.wstrb) begin
                  next_st.bvalid    = 1'b0;
                  next_st.push      = 1'b1;
                  next_st.push_item = st.wdata;
               end
            end
            `DLT_IDX_STATUS: begin
               if (st.wstrb && st.wdata[`DLT_STAT_EOT]) begin
                  next_st.eot = 1'b0;
               end
            end
            default: begin
               next_st.bresp = `DLT_RESP_SLVERR;
            end
         endcase
      end
      // Queue push completes the data write; a full queue stalls the response
      if (st.push && fifo_in_ready) begin
         next_st.push   = 1'b0;
         next_st.bvalid = 1'b1;
      end
      if (st.bvalid && BREADY) begin
         next_st.bvalid = 1'b0;
         next_st.aw_rdy = 1'b1;
         next_st.w_rdy  = 1'b1;
      end
      // Read path
      if (ARVALID && st.ar_rdy) begin
         next_st.ar_rdy = 1'b0;
         next_st.rvalid = 1'b1;
         next_st.rresp  = `DLT_RESP_OKAY;
         next_st.rdata  = 8'h00;
         case (ridx)
            `DLT_IDX_CTRL: next_st.rdata = {5'h00, st.ctrl};
            `DLT_IDX_COUNT: next_st.rdata = {1'b0, st.count};
            `DLT_IDX_BOSCODE: next_st.rdata = st.boscode;
            `DLT_IDX_DATA: next_st.rdata = 8'h00;
            `DLT_IDX_STATUS: begin
               next_st.rdata = {5'h00, fifo_valid, (st.txs != dlt_pkg::ST_FLAG), st.eot};
            end
            default: next_st.rresp = `DLT_RESP_SLVERR;
         endcase
      end
      if (st.rvalid && RREADY) begin
         next_st.rvalid = 1'b0;
         next_st.ar_rdy = 1'b1;
      end
      // A type change to message mode withdraws a waiting BIT_ORIENTED_SIGNALING request
      if (st.ctrl.message_oriented_signaling) begin
         next_st.bos_pend = next_st.bos_pend & ctrl_wr;
      end
      // One line bit per slot, with a stuffed zero after five ones
      if (DL_SLOT) begin
         if (st.ones == `DLT_STUFF_RUN) begin
            next_st.dl_bit = 1'b0;
            next_st.ones   = 3'h0;
         end else begin
            b              = st.sh[0];
            next_st.dl_bit = b;
            next_st.sh     = st.sh >> 1;
            next_st.left   = st.left - 5'h01;
            if ((st.txs == dlt_pkg::ST_DATA || st.txs == dlt_pkg::ST_FCS) && b) begin
               next_st.ones = st.ones + 3'h1;
            end else begin
               next_st.ones = 3'h0;
            end
            if (st.txs == dlt_pkg::ST_DATA) begin
               next_st.crc = (st.crc >> 1) ^ ((st.crc[0] ^ b) ? `DLT_CRC_POLY : 16'h0000);
            end
            done = (st.left == 5'h01);
         end
      end
      // Choose the next unit when the current one has gone out
      if (done) begin
         case (st.txs)
            dlt_pkg::ST_FLAG: begin
               if (st.bos_pend && !st.ctrl.message_oriented_signaling) begin
                  next_st.bos_pend = 1'b0;
                  next_st.reps     = 7'h00;
                  next_st.txs      = dlt_pkg::ST_BOS;
                  next_st.sh       = {st.boscode, `DLT_BOS_LEAD};
                  next_st.left     = `DLT_WORD_BITS;
               end else if (st.ctrl.message_oriented_signaling && !idle_on && fifo_valid) begin
                  want_octet  = 1'b1;
                  next_st.crc = `DLT_CRC_INIT;
               end else begin
                  want_flag = 1'b1;
               end
            end
            dlt_pkg::ST_DATA: begin
               if (idle_on) begin
                  want_flag = 1'b1;
               end else if (st.last) begin
                  if (fcs_on) begin
                     next_st.txs  = dlt_pkg::ST_FCS;
                     next_st.sh   = ~next_st.crc;
                     next_st.left = `DLT_WORD_BITS;
                  end else begin
                     want_flag = 1'b1;
                  end
               end else if (fifo_valid) begin
                  want_octet = 1'b1;
               end else begin
                  want_flag = 1'b1;
               end
            end
            dlt_pkg::ST_BOS: begin
               next_st.reps = st.reps + 7'h01;
               if (!st.ctrl.message_oriented_signaling && (st.count == `DLT_COUNT_RST ||
                   next_st.reps != st.count)) begin
                  next_st.sh   = {st.boscode, `DLT_BOS_LEAD};
                  next_st.left = `DLT_WORD_BITS;
               end else begin
                  want_flag = 1'b1;
                  if (st.count != `DLT_COUNT_RST && next_st.reps == st.count) begin
                     next_st.eot = 1'b1;
                  end
               end
            end
            default: begin
               want_flag = 1'b1;
            end
         endcase
      end
      if (want_octet) begin
         pop             = 1'b1;
         next_st.txs     = dlt_pkg::ST_DATA;
         next_st.sh      = {8'h00, fifo_head.octet};
         next_st.last    = fifo_head.last;
         next_st.left    = `DLT_OCTET_BITS;
      end
      if (want_flag) begin
         next_st.txs  = dlt_pkg::ST_FLAG;
         next_st.sh   = {8'h00, `DLT_FLAG};
         next_st.left = `DLT_OCTET_BITS;
      end
      // Forced idle throws queued frames away between frames
      if (idle_on && st.txs != dlt_pkg::ST_DATA && !want_octet && fifo_valid) begin
         pop = 1'b1;
      end
   end

   // State register with defined reset values
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         st         <= '0;
         st.aw_rdy  <= 1'b1;
         st.w_rdy   <= 1'b1;
         st.ar_rdy  <= 1'b1;
         st.ctrl    <= `DLT_CTRL_RST;
         st.count   <= `DLT_COUNT_RST;
         st.boscode <= `DLT_BOSCODE_RST;
         st.txs     <= dlt_pkg::ST_FLAG;
         st.sh      <= {8'h00, `DLT_FLAG};
         st.left    <= `DLT_OCTET_BITS;
         st.crc     <= `DLT_CRC_INIT;
         st.dl_bit  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   chk_idle_no_frame: assert property (@(posedge CLOCK) disable iff (!RST_N)
      idle_on && st.txs == dlt_pkg::ST_FLAG |=> st.txs != dlt_pkg::ST_DATA)
      else $error("frame started while idle forced");
   chk_idle_flushes: assert property (@(posedge CLOCK) disable iff (!RST_N)
      idle_on && st.txs == dlt_pkg::ST_FLAG && fifo_valid |-> pop)
      else $error("queued frame kept while idle forced");
   chk_flag_fill: assert property (@(posedge CLOCK) disable iff (!RST_N)
      st.txs == dlt_pkg::ST_FLAG && done && !fifo_valid && !st.bos_pend
      |=> st.txs == dlt_pkg::ST_FLAG && st.sh[7:0] == `DLT_FLAG)
      else $error("flag fill not reloaded");
   chk_bos_keeps: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !st.ctrl.message_oriented_signaling && st.ctrl.idle && fifo_valid && st.txs != dlt_pkg::ST_DATA |-> !pop)
      else $error("idle bit acted in bit-oriented mode");
   chk_fcs_appends: assert property (@(posedge CLOCK) disable iff (!RST_N)
      st.txs == dlt_pkg::ST_DATA && done && st.last && fcs_on && !idle_on
      |=> st.txs == dlt_pkg::ST_FCS)
      else $error("check octets not appended");
   chk_fcs_gated: assert property (@(posedge CLOCK) disable iff (!RST_N)
      st.txs != dlt_pkg::ST_FCS ##1 st.txs == dlt_pkg::ST_FCS |-> $past(fcs_on))
      else $error("check octets sent without message mode and enable");
   chk_bos_start: assert property (@(posedge CLOCK) disable iff (!RST_N)
      st.txs == dlt_pkg::ST_FLAG && done && st.bos_pend && !st.ctrl.message_oriented_signaling
      |=> st.txs == dlt_pkg::ST_BOS && st.left == `DLT_WORD_BITS)
      else $error("bit-oriented message not started");
   chk_bos_request: assert property (@(posedge CLOCK) disable iff (!RST_N)
      ctrl_wr && !st.wdata[`DLT_CTRL_TYPE] |=> st.bos_pend)
      else $error("type write of zero did not request a message");
   chk_bos_count_eot: assert property (@(posedge CLOCK) disable iff (!RST_N)
      st.txs == dlt_pkg::ST_BOS && done && st.count != `DLT_COUNT_RST &&
      st.reps + 7'h01 == st.count |=> st.eot && st.txs == dlt_pkg::ST_FLAG)
      else $error("repeat count end not flagged");
   chk_fcs_length: assert property (@(posedge CLOCK) disable iff (!RST_N)
      st.txs != dlt_pkg::ST_FCS ##1 st.txs == dlt_pkg::ST_FCS
      |-> st.left == `DLT_WORD_BITS && st.sh == ~$past(next_st.crc))
      else $error("check sequence not the 16-bit complement");
endmodule

// ==== dlt_remote_model.sv ====
// Receiving terminal model: finds flags, frames and bit-oriented units on the datalink
`timescale 1ns/1ns
`include "dlt_defs.svh"
module dlt_remote_model (
   input  wire logic        clock,        // System clock
   input  wire logic        rst_n,        // Synchronous reset, active low
   input  wire logic        slot,         // Bit slot strobe
   input  wire logic        line_bit,     // Line bit from the transmitter
   output logic [15:0]      flag_count,   // Flags seen
   output logic [7:0]       frame_count,  // Frames closed by a flag
   output logic [7:0]       bos_count,    // Runs of eight ones seen
   output logic [3:0]       frame_len,    // Octets in the last frame
   output logic [63:0]      frame_bytes   // Last frame, first octet lowest
);
   logic        take;
   logic        hunt;
   logic [7:0]  raw;
   logic [7:0]  oct;
   logic [3:0]  ones;
   logic [3:0]  n;
   logic [3:0]  nb;
   logic [63:0] acc;

   // Bit taken one cycle after its slot, once the line has settled
   always @(posedge clock) begin
      take <= slot;
      if (!rst_n) begin
         {flag_count, frame_count, bos_count, frame_len, frame_bytes} = '0;
         {raw, oct, ones, n, nb, acc} = '0;
         hunt = 1'b1;
      end else if (take) begin
         raw = {line_bit, raw[7:1]};
         if (raw == `DLT_FLAG) begin
            flag_count++;
            if (!hunt && n != 4'h0) begin
               frame_count++;
               frame_len = n;
               frame_bytes = acc;
            end
            {hunt, n, nb, acc} = '0;
         end else if (ones == 4'h5 && !line_bit) begin
            // Stuffed zero is dropped
         end else if (!hunt) begin
            oct = {line_bit, oct[7:1]};
            nb++;
            if (nb == 4'h8) begin
               acc[n*8 +: 8] = oct;
               n++;
               nb = 4'h0;
            end
         end
         ones = line_bit ? ones + 4'h1 : 4'h0;
         if (ones == 4'h7) hunt = 1'b1;
         if (ones == 4'h8) bos_count++;
      end
   end
endmodule

// ==== hdlc3_datalink_tx_control_test.sv ====
// Self-checking bench of the datalink 3 transmit control block
`timescale 1ns/1ns
`include "dlt_defs.svh"
module hdlc3_datalink_tx_control_test;
   localparam logic [11:0] A_CTRL = {`DLT_IDX_CTRL, 2'b00};
   localparam logic [11:0] A_CNT  = {`DLT_IDX_COUNT, 2'b00};
   localparam logic [11:0] A_DATA = {`DLT_IDX_DATA, 2'b00};
   localparam logic [11:0] A_STAT = {`DLT_IDX_STATUS, 2'b00};
   localparam logic [11:0] A_CODE = {`DLT_IDX_BOSCODE, 2'b00};
   localparam logic [11:0] A_HOLE = 12'h554;
   logic        CLOCK = 1'b0, RST_N = 1'b0, DL_SLOT = 1'b0, slot_en = 1'b1;
   logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
   logic [31:0] WDATA = 32'h0000_0000, RDATA;
   logic [3:0]  WSTRB = 4'hF;
   logic [1:0]  BRESP, RRESP;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, DL_BIT, TX_EOT;
   logic [15:0] flags;
   logic [7:0]  frames, bit_oriented_signaling;
   logic [3:0]  flen;
   logic [63:0] fbytes;
   logic [31:0] seed = 32'h7ECF;
   logic [11:0] reset_map [5] = '{A_CTRL, A_CNT, A_DATA, A_STAT, A_CODE};
   int          bad_count = 0;
   int          tests_run = 0;

   // 250 MHz clock and a datalink slot on every other cycle while enabled
   always #2 CLOCK = ~CLOCK;
   always @(posedge CLOCK) DL_SLOT <= slot_en & ~DL_SLOT;

   dlt_tx_ctrl i_dut (
      .CLOCK(CLOCK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
      .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .DL_SLOT(DL_SLOT), .DL_BIT(DL_BIT), .TX_EOT(TX_EOT)
   );
   dlt_remote_model i_far (
      .clock(CLOCK), .rst_n(RST_N), .slot(DL_SLOT), .line_bit(DL_BIT), .flag_count(flags),
      .frame_count(frames), .bos_count(bit_oriented_signaling), .frame_len(flen), .frame_bytes(fbytes)
   );

   // Repeatable xorshift source
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected check octets: inverted reflected CRC, low octet first on the line
   function automatic logic [15:0] fcs16(input logic [63:0] b, input int n);
      logic [15:0] c;
      c = `DLT_CRC_INIT;
      for (int i = 0; i < n; i++) begin
         c = c ^ {8'h00, b[i*8 +: 8]};
         for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ `DLT_CRC_POLY) : (c >> 1);
      end
      return ~c;
   endfunction

   task automatic report_and_stop();
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
         bad_count++;
      end
   endtask

   task automatic give_up(input string what);
      check(1'b0, 1'b1, what);
      report_and_stop();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask

   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic [31:0] v;
      v = xs();
      @(posedge CLOCK);
      AWADDR <= a;
      WDATA <= d;
      WSTRB <= {v[3:1], 1'b1};
      {AWVALID, WVALID, BREADY} <= 3'b111;
      for (n = 0; n < 3000; n++) begin
         @(posedge CLOCK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         if (BVALID) break;
      end
      BREADY <= 1'b0;
      if (n == 3000) give_up("write wait");
      check(BRESP, er, "write response");
   endtask

   // Read and compare data with response
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge CLOCK);
      ARADDR <= a;
      {ARVALID, RREADY} <= 2'b11;
      for (n = 0; n < 3000; n++) begin
         @(posedge CLOCK);
         if (ARREADY) ARVALID <= 1'b0;
         if (RVALID) break;
      end
      RREADY <= 1'b0;
      if (n == 3000) give_up("read wait");
      check({RRESP, RDATA}, {er, ed}, "read");
   endtask

   // Bounded wait on the frame count or on the end-of-transfer pin
   task automatic wait_until(input int sel, input logic [7:0] tgt);
      int n;
      for (n = 0; n < 4000; n++) begin
         if ((sel == 0 ? frames : {7'h00, TX_EOT}) === tgt) break;
         cyc(1);
      end
      if (n == 4000) give_up("line wait");
   endtask

   initial begin
      logic [31:0] d;
      logic [63:0] exp;
      logic [7:0]  f0, b0;
      logic [15:0] fl0;
      int          len;
      repeat (8) @(posedge CLOCK);
      RST_N <= 1'b1;
      #1;
      check({DL_BIT, TX_EOT}, 2'b10, "reset pins");
      // Reset values, the hole in the map and the idle line
      fl0 = flags;
      for (int i = 0; i < 5; i++) rd(reset_map[i], 32'h0, `DLT_RESP_OKAY);
      rd(A_HOLE, 32'h0, `DLT_RESP_SLVERR);
      wr(A_HOLE, 32'h1, `DLT_RESP_SLVERR);
      cyc(200);
      check(flags - fl0 > 16'h0005, 1'b1, "flags on idle line");
      check(frames, 8'h00, "no frame on idle line");
      wr(A_CTRL, 32'hFF, `DLT_RESP_OKAY);
      rd(A_CTRL, 32'h07, `DLT_RESP_OKAY);
      // Frames with and without check octets; the line stalls while the FIFO fills
      for (int k = 0; k < 6; k++) begin
         len = (k == 0) ? 1 : (k == 1) ? 6 : 1 + xs() % 6;
         wr(A_CTRL, k[0] ? 32'h01 : 32'h03, `DLT_RESP_OKAY);
         f0 = frames;
         exp = 64'h0;
         slot_en <= 1'b0;
         for (int i = 0; i < len; i++) begin
            d = xs();
            exp[i*8 +: 8] = d[7:0];
            if (i == 4) begin
               rd(A_STAT, 32'h4, `DLT_RESP_OKAY);
               slot_en <= 1'b1;
            end
            wr(A_DATA, {23'h0, i == len - 1, d[7:0]}, `DLT_RESP_OKAY);
         end
         slot_en <= 1'b1;
         if (!k[0]) exp[len*8 +: 16] = fcs16(exp, len);
         wait_until(0, f0 + 8'h01);
         check(flen, len + (k[0] ? 0 : 2), "frame length");
         check(fbytes, exp, "frame octets");
      end
      // Idle force drops queued octets and keeps flags going
      f0 = frames;
      wr(A_CTRL, 32'h05, `DLT_RESP_OKAY);
      wr(A_DATA, 32'h03C, `DLT_RESP_OKAY);
      wr(A_DATA, 32'h1C3, `DLT_RESP_OKAY);
      cyc(300);
      rd(A_STAT, 32'h0, `DLT_RESP_OKAY);
      wr(A_CTRL, 32'h01, `DLT_RESP_OKAY);
      cyc(300);
      check(frames, f0, "frame under idle");
      // Bit-oriented runs of one and three units with idle and check bits set
      wr(A_CODE, 32'h12, `DLT_RESP_OKAY);
      for (int j = 1; j < 4; j += 2) begin
         b0 = bit_oriented_signaling;
         f0 = frames;
         wr(A_CNT, j, `DLT_RESP_OKAY);
         wr(A_CTRL, 32'h06, `DLT_RESP_OKAY);
         wait_until(1, 8'h01);
         check(bit_oriented_signaling - b0, j, "units sent");
         check(frames, f0, "no frame in units");
         rd(A_STAT, 32'h1, `DLT_RESP_OKAY);
         wr(A_STAT, 32'h1, `DLT_RESP_OKAY);
         check(TX_EOT, 1'b0, "end of transfer cleared");
      end
      // Count zero repeats until the type goes back to message frames
      b0 = bit_oriented_signaling;
      wr(A_CNT, 32'h0, `DLT_RESP_OKAY);
      wr(A_CTRL, 32'h00, `DLT_RESP_OKAY);
      cyc(640);
      check(bit_oriented_signaling - b0 > 8'd15, 1'b1, "endless units");
      check(TX_EOT, 1'b0, "no end when endless");
      wr(A_CTRL, 32'h01, `DLT_RESP_OKAY);
      cyc(100);
      b0 = bit_oriented_signaling;
      cyc(200);
      check(bit_oriented_signaling, b0, "units stopped");
      report_and_stop();
   end
endmodule
